// ---- core/txc_dev_end.sv ----
// Purpose: Transmit command parser; splits command words from payload
// Assumes: Host end keeps word order; downstream FIFO has pay_ready
// Notes:   One output stage toward the FIFO; padding and offset bytes dropped
//          Flags are one-cycle pulses; the host end makes them sticky
//
// Notes on behaviour
// RL1 - Commands always precede their buffer payload
// RL2 - Command is two 32-bit words, A then B
// RL3 - Every buffer carries both A and B
// RL4 - Host repeats identical B within a packet
// RL5 - B mismatch inside packet raises transmit error
// RL6 - B holds 16-bit tag, kept uninterpreted
// RL7 - Tag returned with packet status
// RL8 - A bit 31 flags buffer fully loaded
// RL9 - Reserved A bits written zero, ignored
// RL10 - A 25:24 selects 4/16/32-byte end alignment
// RL11 - Host pads buffer to alignment boundary
// RL12 - Padding words are discarded
// RL13 - Commands and dropped bytes never stored
// RL14 - A 20:16 skips leading offset bytes
// RL15 - A bit 13 first, bit 12 last segment
// RL16 - Summed sizes must equal B packet length
// RL17 - Tag taken from B bits 31:16
// RL18 - A first, then B after each buffer
// RL19 - Buffer words: offset plus size, aligned up
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module txc_dev_end (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Word link from the host end
  txc_if.dev               lnk,
  // Payload toward the transmit data FIFO
  output logic             pay_valid,
  output logic [31:0]      pay_data,
  output logic [3:0]       pay_be,
  output logic             pay_eop,
  input  wire logic        pay_ready
);

  typedef struct packed {
    txc_pkg::txc_dst_t st;
    logic [31:0]       cmd_a;
    logic [31:0]       cmd_b;
    logic              in_pkt;
    logic [15:0]       sum;
    logic [9:0]        total;
    logic [9:0]        widx;
    logic              pv;
    logic [31:0]       pd;
    logic [3:0]        pbe;
    logic              peop;
    logic              err;
    logic              done;
    logic              tagv;
    logic [15:0]       tag;
  } txc_dev_state_t;

  txc_dev_state_t r;
  txc_dev_state_t n;

  logic        take;
  logic        fin;
  logic [11:0] off;
  logic [11:0] pend;
  logic [11:0] pos;
  logic [9:0]  lastw;
  logic [9:0]  nwords;
  logic [3:0]  be;
  logic        last_word;

  // Command A fields of the buffer in flight
  logic        a_first;
  logic        a_last;
  logic        a_ioc;
  logic [10:0] a_size;

  assign a_first   = r.cmd_a[txc_pkg::FIRST_SEGMENT_FLAG];
  assign a_last    = r.cmd_a[txc_pkg::A_LAST_SEG_BIT];
  assign a_ioc     = r.cmd_a[txc_pkg::A_IOC_BIT];
  assign a_size    = r.cmd_a[txc_pkg::A_SIZE_MSB:0];
  assign last_word = (r.widx == r.total - 10'h001);

  // Commands and padding are always sunk; payload waits on the output stage
  always_comb begin
    if (r.st == txc_pkg::D_DATA) begin
      // Words without payload bytes need no output slot
      lnk.word_ready = !r.pv || pay_ready || (be == 4'h0); // RL13
    end else begin
      lnk.word_ready = 1'b1; // RL13
    end
  end

  assign take = lnk.word_valid && lnk.word_ready;

  // Byte window of the payload inside the buffer
  assign off    = 12'(r.cmd_a[txc_pkg::A_OFF_MSB:txc_pkg::A_OFF_LSB]);
  assign pend   = off + 12'(a_size);
  // Wraps for an empty window at offset zero; then no payload word matches it
  assign lastw  = 10'((pend - 12'h001) >> 2);
  assign nwords = txc_pkg::txc_buf_words(r.cmd_a); // RL19 RL10

  always_comb begin
    be  = 4'h0;
    pos = 12'h000;
    for (int i = 0; i < 4; i++) begin
      pos   = {r.widx, 2'b00} + 12'(i);
      be[i] = (pos >= off) && (pos < pend); // RL14 RL12
    end
  end

  always_comb begin
    n      = r;
    n.err  = 1'b0;
    n.done = 1'b0;
    n.tagv = 1'b0;
    fin    = 1'b0;
    if (r.pv && pay_ready) begin
      n.pv = 1'b0;
    end
    unique case (r.st)
      txc_pkg::D_CMDA: begin
        // First word after a finished buffer is always command A
        if (take) begin // RL18 RL1
          n.cmd_a = lnk.word_data; // RL9
          n.st    = txc_pkg::D_CMDB; // RL2 RL3
        end
      end
      txc_pkg::D_CMDB: begin
        if (take) begin
          n.cmd_b = lnk.word_data; // RL6
          if (a_first) begin // RL15
            n.sum = 16'(a_size);
            // New packet opened while one is still open
            if (r.in_pkt) begin
              n.err = 1'b1;
            end
          end else begin
            n.sum = r.sum + 16'(a_size); // RL16
            if (!r.in_pkt || lnk.word_data != r.cmd_b) begin
              n.err = 1'b1; // RL5 RL4
            end
          end
          n.in_pkt = 1'b1;
          n.total  = nwords;
          n.widx   = 10'h000;
          if (nwords == 10'h000) begin
            fin = 1'b1;
          end else begin
            n.st = txc_pkg::D_DATA;
          end
        end
      end
      txc_pkg::D_DATA: begin
        if (take) begin
          // Words without payload bytes are dropped here
          if (be != 4'h0) begin // RL12 RL13
            n.pv   = 1'b1;
            n.pd   = lnk.word_data;
            n.pbe  = be;
            n.peop = a_last && (r.widx == lastw);
          end
          n.widx = r.widx + 10'h001;
          if (last_word) begin // RL19
            fin = 1'b1;
          end
        end
      end
      default: begin
        n.st = txc_pkg::D_CMDA;
      end
    endcase
    if (fin) begin
      n.st   = txc_pkg::D_CMDA; // RL18
      n.done = a_ioc; // RL8
      // Length and tag checks use the B word of this buffer
      if (a_last) begin // RL15
        n.in_pkt = 1'b0;
        n.tagv   = 1'b1; // RL7
        n.tag    = n.cmd_b[txc_pkg::B_TAG_MSB:txc_pkg::B_TAG_LSB]; // RL17
        if (n.sum != 16'(n.cmd_b[txc_pkg::B_LEN_MSB:0])) begin
          n.err = 1'b1; // RL16
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r    <= '0;
      r.st <= txc_pkg::D_CMDA;
    end else begin
      r <= n;
    end
  end

  assign pay_valid               = r.pv;
  assign pay_data                = r.pd;
  assign pay_be                  = r.pbe;
  assign pay_eop                 = r.peop;
  assign lnk.transmit_error_flag = r.err;
  assign lnk.buffer_loaded_flag  = r.done;
  assign lnk.tag_valid           = r.tagv;
  assign lnk.tag                 = r.tag;

endmodule // txc_dev_end
`default_nettype wire

// ---- core/txc_host_end.sv ----
// Purpose: Host end; turns register writes into command and payload words
// Assumes: Avalon-MM slave with waitrequest, byte addresses
// Notes:   Sends A then B, forwards payload, appends zero padding itself
`timescale 1ns/10ps
`default_nettype none
module txc_host_end (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt
  output logic             irq,
  // Word link to the parser
  txc_if.host              lnk
);

  typedef struct packed {
    txc_pkg::txc_hst_t st;
    logic [31:0]       cmd_a;
    logic [31:0]       cmd_b;
    logic [9:0]        left;
    logic [9:0]        pad;
    logic              wv;
    logic [31:0]       wd;
    logic [2:0]        status;
    logic [2:0]        mask;
    logic [15:0]       tag;
  } txc_hst_state_t;

  txc_hst_state_t r;
  txc_hst_state_t n;

  logic        hs;
  logic        wr_data;
  logic [31:0] a_clean;
  logic [9:0]  left_m1;
  logic [2:0]  ev;

  assign hs      = r.wv && lnk.word_ready;
  assign wr_data = avs_write && avs_address == txc_pkg::REG_DATA;
  assign left_m1 = r.left - 10'h001;
  assign ev      = {lnk.tag_valid, lnk.buffer_loaded_flag, lnk.transmit_error_flag};

  // Reserved bits cleared; reserved alignment code falls back to 4-byte
  always_comb begin
    a_clean = r.cmd_a & txc_pkg::A_USED_MASK; // RL9
    if (a_clean[txc_pkg::A_ALIGN_MSB:txc_pkg::A_ALIGN_LSB] == txc_pkg::AL_RSVD) begin
      a_clean[txc_pkg::A_ALIGN_MSB:txc_pkg::A_ALIGN_LSB] = txc_pkg::AL_4; // RL10
    end
  end

  // Only payload stalls; commands and padding hold the bus off too
  always_comb begin
    avs_waitrequest = 1'b0;
    if (wr_data && r.st != txc_pkg::H_IDLE) begin
      avs_waitrequest = (r.st != txc_pkg::H_DATA) || r.wv;
    end
  end

  always_comb begin
    n = r;
    if (hs) begin
      n.wv = 1'b0;
    end
    unique case (r.st)
      txc_pkg::H_IDLE: begin
        // Writing command B launches the buffer
        if (avs_write && avs_address == txc_pkg::REG_CMDB) begin
          n.cmd_b = avs_writedata;
          n.wd    = a_clean; // RL18 RL1
          n.wv    = 1'b1;
          n.left  = txc_pkg::txc_buf_words(a_clean);
          n.pad   = txc_pkg::txc_buf_words(a_clean) - txc_pkg::txc_need_words(a_clean);
          n.st    = txc_pkg::H_CMDA;
        end else if (avs_write && avs_address == txc_pkg::REG_CMDA) begin
          n.cmd_a = avs_writedata;
        end
      end
      txc_pkg::H_CMDA: begin
        if (hs) begin
          n.wd = r.cmd_b; // RL2 RL3 RL4
          n.wv = 1'b1;
          n.st = txc_pkg::H_CMDB;
        end
      end
      txc_pkg::H_CMDB: begin
        if (hs) begin
          if (r.left == 10'h000) begin
            n.st = txc_pkg::H_IDLE;
          end else if (r.left == r.pad) begin
            n.st = txc_pkg::H_PAD;
            n.wd = 32'h0000_0000;
            n.wv = 1'b1;
          end else begin
            n.st = txc_pkg::H_DATA;
          end
        end
      end
      txc_pkg::H_DATA: begin
        if (hs) begin
          n.left = left_m1;
          if (left_m1 == 10'h000) begin
            n.st = txc_pkg::H_IDLE;
          end else if (left_m1 == r.pad) begin
            n.st = txc_pkg::H_PAD;
            n.wd = 32'h0000_0000;
            n.wv = 1'b1;
          end
        end
        if (wr_data && !r.wv) begin
          n.wd = avs_writedata;
          n.wv = 1'b1;
        end
      end
      txc_pkg::H_PAD: begin
        // Zero words up to the end alignment
        if (hs) begin // RL11
          n.left = left_m1;
          if (left_m1 == 10'h000) begin
            n.st = txc_pkg::H_IDLE;
          end else begin
            n.wv = 1'b1;
          end
        end
      end
      default: begin
        n.st = txc_pkg::H_IDLE;
        n.wv = 1'b0;
      end
    endcase
    // Set beats a same-cycle write-one-to-clear
    if (avs_write && avs_address == txc_pkg::REG_STATUS) begin
      n.status = r.status & ~avs_writedata[2:0];
    end
    n.status = n.status | ev;
    if (avs_write && avs_address == txc_pkg::REG_MASK) begin
      n.mask = avs_writedata[2:0];
    end
    if (lnk.tag_valid) begin
      n.tag = lnk.tag;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r        <= '0;
      r.st     <= txc_pkg::H_IDLE;
      r.status <= txc_pkg::STATUS_RESET;
    end else begin
      r <= n;
    end
  end

  always_comb begin
    avs_readdata = 32'h0000_0000;
    if (avs_read) begin
      unique case (avs_address)
        txc_pkg::REG_CMDA:   avs_readdata = r.cmd_a;
        txc_pkg::REG_CMDB:   avs_readdata = r.cmd_b;
        txc_pkg::REG_STATUS: avs_readdata = {29'h0, r.status};
        txc_pkg::REG_MASK:   avs_readdata = {29'h0, r.mask};
        txc_pkg::REG_TAG:    avs_readdata = {16'h0, r.tag};
        txc_pkg::REG_STATE:  avs_readdata = {19'h0, r.st, r.left};
        default:             avs_readdata = 32'h0000_0000;
      endcase
    end
  end

  assign irq            = |(r.status & r.mask);
  assign lnk.word_valid = r.wv;
  assign lnk.word_data  = r.wd;

endmodule // txc_host_end
`default_nettype wire

// ---- core/txc_if.sv ----
// Purpose: Word link between the host end and the command parser
// Assumes: Both ends on one clock
// Notes:   A word moves on a clock edge where word_valid and word_ready are high
`timescale 1ns/10ps
`default_nettype none
interface txc_if;
  logic        word_valid;
  logic [31:0] word_data;
  logic        word_ready;
  logic        transmit_error_flag;
  logic        buffer_loaded_flag;
  logic        tag_valid;
  logic [15:0] tag;

  modport dev (
    input  word_valid,
    input  word_data,
    output word_ready,
    output transmit_error_flag,
    output buffer_loaded_flag,
    output tag_valid,
    output tag
  );

  modport host (
    output word_valid,
    output word_data,
    input  word_ready,
    input  transmit_error_flag,
    input  buffer_loaded_flag,
    input  tag_valid,
    input  tag
  );
endinterface
`default_nettype wire

// ---- core/txc_pkg.sv ----
// Purpose: Shared constants, types and helpers of the transmit command link
// Assumes: 32-bit command and data words
// Notes:   Command A/B field layout, host register map, status bit layout
package txc_pkg;

  // Command A fields
  localparam int A_IOC_BIT          = 31;
  localparam int A_ALIGN_MSB        = 25;
  localparam int A_ALIGN_LSB        = 24;
  localparam int A_OFF_MSB          = 20;
  localparam int A_OFF_LSB          = 16;
  localparam int FIRST_SEGMENT_FLAG = 13;
  localparam int A_LAST_SEG_BIT     = 12;
  localparam int A_SIZE_MSB         = 10;
  // Bits the host may set; every reserved bit is zero here
  localparam logic [31:0] A_USED_MASK = 32'h831f_37ff;

  // Command B fields
  localparam int B_TAG_MSB = 31;
  localparam int B_TAG_LSB = 16;
  localparam int B_LEN_MSB = 10;

  // Buffer end alignment codes
  localparam logic [1:0] AL_4    = 2'h0;
  localparam logic [1:0] AL_16   = 2'h1;
  localparam logic [1:0] AL_32   = 2'h2;
  localparam logic [1:0] AL_RSVD = 2'h3;

  // Host register byte offsets
  localparam logic [4:0] REG_CMDA   = 5'h00;
  localparam logic [4:0] REG_CMDB   = 5'h04;
  localparam logic [4:0] REG_DATA   = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0c;
  localparam logic [4:0] REG_MASK   = 5'h10;
  localparam logic [4:0] REG_TAG    = 5'h14;
  localparam logic [4:0] REG_STATE  = 5'h18;

  // Status and mask bits
  localparam int ST_ERR  = 0;
  localparam int ST_DONE = 1;
  localparam int ST_TAG  = 2;
  localparam logic [2:0] STATUS_RESET = 3'h0;

  typedef enum logic [1:0] {
    D_CMDA = 2'b00,
    D_CMDB = 2'b01,
    D_DATA = 2'b11
  } txc_dst_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_CMDA = 3'b001,
    H_CMDB = 3'b011,
    H_DATA = 3'b010,
    H_PAD  = 3'b110
  } txc_hst_t;

  // Words holding offset plus payload bytes
  function automatic logic [9:0] txc_need_words(input logic [31:0] a);
    logic [11:0] bytes;
    bytes = 12'(a[A_OFF_MSB:A_OFF_LSB]) + 12'(a[A_SIZE_MSB:0]) + 12'h003;
    return bytes[11:2];
  endfunction

  // Words the buffer occupies after end alignment
  function automatic logic [9:0] txc_buf_words(input logic [31:0] a);
    logic [9:0] m;
    unique case (a[A_ALIGN_MSB:A_ALIGN_LSB])
      AL_16:   m = 10'h003;
      AL_32:   m = 10'h007;
      default: m = 10'h000;
    endcase
    return (txc_need_words(a) + m) & ~m;
  endfunction

endpackage

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench for host end and parser joined by the link
// Assumes: 50 MHz clock, sync active-low reset
// Notes:   Payload bytes and status checked against bench expectations
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic        pay_valid, pay_eop, pay_ready;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, pay_data, q;
  logic [3:0]  pay_be;
  logic [7:0]  got[$], exp_q[$];
  int          n_fail, n_compared, n_eop, eop_at;
  txc_if lnk ();
  txc_host_end i_txc_host_end (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .lnk(lnk.host));
  txc_dev_end i_txc_dev_end (.clk(clk), .rst_n(rst_n), .lnk(lnk.dev), .pay_valid(pay_valid),
    .pay_data(pay_data), .pay_be(pay_be), .pay_eop(pay_eop), .pay_ready(pay_ready));
  txc_assertions i_txc_assertions (.clk(clk), .rst_n(rst_n), .word_valid(lnk.word_valid),
    .word_data(lnk.word_data), .word_ready(lnk.word_ready), .transmit_error_flag(lnk.transmit_error_flag),
    .buffer_loaded_flag(lnk.buffer_loaded_flag), .tag_valid(lnk.tag_valid), .tag(lnk.tag));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // FIFO side stalls at random to exercise back-pressure
  always @(posedge clk) begin
    pay_ready <= ($urandom % 4) != 0;
    if (rst_n && pay_valid && pay_ready) begin
      for (int i = 0; i < 4; i++) if (pay_be[i]) got.push_back(pay_data[8*i +: 8]);
      if (pay_eop) begin
        n_eop++;
        eop_at = got.size();
      end
    end
  end
  function automatic int need_words(input logic [31:0] a);
    return (int'(a[20:16]) + int'(a[10:0]) + 3) / 4;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic [4:0] ad, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    int t;
    t = 0;
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    // Waitrequest and read data are taken at the same rising edge
    do begin
      @(posedge clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 3000);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) chk("waitrequest", 32'h1, 32'h0);
    @(posedge clk);
  endtask
  task automatic wait_idle(input logic all_bytes);
    int t;
    t = 0;
    do begin
      bus(5'h18, 1'b0, 32'h0, q);
      t++;
    end while ((q[12:10] != 3'h0 || (all_bytes && got.size() < exp_q.size())) && t < 400);
    chk("host idle", {29'h0, q[12:10]}, 32'h0);
  endtask
  task automatic buf_send(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] d;
    int          need;
    need = need_words(a);
    // Command writes are dropped unless the host end is idle
    wait_idle(1'b0);
    bus(5'h00, 1'b1, a, q);
    bus(5'h04, 1'b1, b, q);
    for (int i = 0; i < need; i++) begin
      d = $urandom;
      for (int k = 0; k < 4; k++)
        if (i * 4 + k >= a[20:16] && i * 4 + k < a[20:16] + a[10:0]) exp_q.push_back(d[8*k +: 8]);
      bus(5'h08, 1'b1, d, q);
    end
  endtask
  task automatic pkt(input int nb, input logic bad_tag, input logic bad_len);
    logic [31:0] a, b, m;
    logic [2:0]  st;
    logic [10:0] sz[3];
    int          e0;
    st = {2'b10, bad_tag | bad_len};
    e0 = n_eop;
    b = $urandom;
    b[15:0] = 16'h0000;
    for (int j = 0; j < nb; j++) begin
      sz[j] = 11'($urandom % 70);
      b[10:0] += sz[j];
    end
    b[10:0] += 11'(bad_len);
    // Reserved fields and alignment code stay random on purpose
    for (int j = 0; j < nb; j++) begin
      a = $urandom;
      a[13:12] = {j == 0, j == nb - 1};
      a[10:0] = sz[j];
      st[1] |= a[31];
      buf_send(a, (bad_tag && j == 1) ? b ^ 32'h0001_0000 : b);
    end
    wait_idle(1'b1);
    repeat (3) @(posedge clk);
    m = $urandom;
    bus(5'h10, 1'b1, m, q);
    bus(5'h10, 1'b0, 32'h0, q);
    chk("mask", q, {29'h0, m[2:0]});
    bus(5'h0c, 1'b0, 32'h0, q);
    chk("status", q, {29'h0, st});
    @(negedge clk);
    chk("irq", {31'h0, irq}, {31'h0, |(st & m[2:0])});
    @(posedge clk);
    if (!bad_tag) begin
      bus(5'h14, 1'b0, 32'h0, q);
      chk("tag", q, {16'h0, b[31:16]});
    end
    bus(5'h0c, 1'b1, 32'h7, q);
    bus(5'h0c, 1'b0, 32'h0, q);
    chk("status clear", q, 32'h0);
    chk("byte count", got.size(), exp_q.size());
    foreach (exp_q[i]) if (i < got.size()) chk("byte", {24'h0, got[i]}, {24'h0, exp_q[i]});
    chk("eop count", n_eop - e0, {31'h0, sz[nb - 1] != 11'h000});
    if (sz[nb - 1] != 11'h000) chk("eop place", eop_at, exp_q.size());
    got.delete();
    exp_q.delete();
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    chk("watchdog", 32'h1, 32'h0);
    test_done;
  end
  initial begin
    n_fail = 0;
    n_compared = 0;
    rst_n = 1'b0;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    void'($urandom(32'h896743c7));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(5'h0c, 1'b0, 32'h0, q);
    chk("status reset", q, 32'h0);
    bus(5'h10, 1'b0, 32'h0, q);
    chk("mask reset", q, 32'h0);
    bus(5'h1c, 1'b0, 32'h0, q);
    chk("unmapped", q, 32'h0);
    // Payload written with no buffer open must vanish
    bus(5'h08, 1'b1, 32'h5a5a_5a5a, q);
    $display("test reset done");
    repeat (16) pkt(1 + $urandom % 3, 1'b0, 1'b0);
    $display("test random packets done");
    pkt(2, 1'b1, 1'b0);
    $display("test tag mismatch done");
    pkt(1, 1'b0, 1'b1);
    $display("test length error done");
    // Continuation with no packet open is flagged, payload still delivered
    buf_send(32'h0000_1010, 32'h00c3_0010);
    wait_idle(1'b1);
    repeat (3) @(posedge clk);
    bus(5'h0c, 1'b0, 32'h0, q);
    chk("orphan status", q, 32'h5);
    bus(5'h14, 1'b0, 32'h0, q);
    chk("orphan tag", q, 32'h0000_00c3);
    chk("orphan bytes", got.size(), exp_q.size());
    $display("test orphan segment done");
    test_done;
  end
endmodule // tb
`default_nettype wire

// ---- testbench/txc_assertions.sv ----
// Purpose: Link checks between host end and parser
// Assumes: One clock, sync active-low reset
// Notes:   Tracks link phase itself to time the flags
`timescale 1ns/10ps
`default_nettype none
module txc_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Link
  input wire logic        word_valid,
  input wire logic [31:0] word_data,
  input wire logic        word_ready,
  input wire logic        transmit_error_flag,
  input wire logic        buffer_loaded_flag,
  input wire logic        tag_valid,
  input wire logic [15:0] tag
);
  function automatic logic [9:0] wds(input logic [31:0] a);
    logic [9:0] n;
    logic [9:0] m;
    n = 10'((12'(a[20:16]) + 12'(a[10:0]) + 12'h003) >> 2);
    m = (a[25:24] == 2'h1) ? 10'h003 : (a[25:24] == 2'h2) ? 10'h007 : 10'h000;
    return (n + m) & ~m;
  endfunction
  logic [1:0]  ph_r;
  logic [9:0]  left_r;
  logic [31:0] a_r;
  logic [31:0] pk_r;
  logic [11:0] sum_r;
  logic [15:0] tag_q;
  logic        open_r, bad_r, done_q, last_q, berr_q, lerr_q;
  wire logic        take = word_valid && word_ready;
  wire logic [9:0]  wn = wds(a_r);
  wire logic        first = ph_r == 2'd1 && a_r[13];
  wire logic [31:0] pk_now = first ? word_data : pk_r;
  wire logic [11:0] sum_now = (ph_r != 2'd1) ? sum_r : (first ? 12'h000 : sum_r) + 12'(a_r[10:0]);
  wire logic        berr = take && ph_r == 2'd1 && !a_r[13] && (!open_r || word_data != pk_r);
  wire logic        fin = take && ((ph_r == 2'd1 && wn == 10'h000) || (ph_r == 2'd2 && left_r == 10'h001));
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ph_r <= 2'd0;
      {open_r, bad_r, done_q, last_q, berr_q, lerr_q} <= 6'h00;
      {left_r, a_r, pk_r, sum_r, tag_q} <= '0;
    end else begin
      done_q <= fin && a_r[31];
      last_q <= fin && a_r[12];
      lerr_q <= fin && a_r[12] && sum_now != {1'b0, pk_now[10:0]};
      berr_q <= berr;
      if (take && ph_r == 2'd0) begin
        a_r <= word_data;
        ph_r <= 2'd1;
      end
      if (take && ph_r == 2'd1) begin
        pk_r <= pk_now;
        sum_r <= sum_now;
        left_r <= wn;
        ph_r <= 2'd2;
        bad_r <= berr || (bad_r && !first);
      end
      if (take && ph_r == 2'd2) left_r <= left_r - 10'h001;
      // Zero-word buffers end on the B word itself
      if (fin) begin
        ph_r <= 2'd0;
        open_r <= !a_r[12];
        tag_q <= pk_now[31:16];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_word_held: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
    else $error("link word changed while stalled");
  a_cmd_ready: assert property (ph_r != 2'd2 |-> word_ready)
    else $error("command word refused");
  a_clean_cmda: assert property (take && ph_r == 2'd0 |-> (word_data & ~txc_pkg::A_USED_MASK) == 32'h0 && word_data[25:24] != 2'h3)
    else $error("command A carries reserved values");
  a_done_flag: assert property (buffer_loaded_flag == done_q)
    else $error("buffer loaded pulse wrong");
  a_tag_pulse: assert property (tag_valid == last_q)
    else $error("tag pulse not at last segment end");
  a_tag_value: assert property (tag_valid && !bad_r |-> tag == tag_q)
    else $error("returned tag wrong");
  a_tag_stable: assert property (!tag_valid |-> $stable(tag))
    else $error("tag changed without pulse");
  a_b_mismatch: assert property (berr_q |-> transmit_error_flag)
    else $error("command B mismatch not flagged");
  a_len_error: assert property (lerr_q |-> transmit_error_flag)
    else $error("length mismatch not flagged");
endmodule // txc_assertions
`default_nettype wire
